/* File: design/fspg_guard.v */
// flash self-program guard: wishbone registers, request gating, swap
`timescale 1ns/10ps
`include "fspg_map.vh"
module fspg_guard #(
    parameter BLK_W     = 8,
    parameter BLK_BYTES = 1024
) (
    input  wire             clk_i,
    input  wire             rst_i,
    // wishbone classic slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    // clock and programming state of the chip
    input  wire             cpu_on_subclk_i,
    input  wire             serial_prog_i,
    input  wire             flash_op_mode_sel_hi_i,
    input  wire             flash_op_mode_sel_lo_i,
    input  wire             fast_osc_stop_bit_i,
    // nonvolatile swap flag storage
    input  wire             nv_swap_i,
    output reg              nv_swap_we_o,
    output reg              nv_swap_o,
    // request towards the flash sequencer
    output reg              fl_req_o,
    output reg              fl_kind_o,
    output reg              fl_data_o,
    output reg  [BLK_W-1:0] fl_blk_o,
    output reg              fl_full_speed_o,
    input  wire             fl_done_i,
    // boot cluster for the reset vector
    output reg  [19:0]      boot_base_o,
    output reg              self_active_o
);
    // register state
    reg             self_q,      self_d;
    reg             vmode_q,     vmode_d;
    reg             bc0prot_q,   bc0prot_d;
    reg [BLK_W-1:0] win_start_q, win_start_d;
    reg [BLK_W-1:0] win_end_q,   win_end_d;
    reg [1:0]       result_q,    result_d;
    reg             busy_q,      busy_d;
    reg             kind_q,      kind_d;
    reg             data_q,      data_d;
    reg [BLK_W-1:0] blk_q,       blk_d;
    reg             ack_d;
    reg [31:0]      rdat_d;
    reg             swap_set,    swap_clr;

    wire            allow;
    wire            in_win;
    wire            in_bc0;
    wire            nv_d;
    wire            boot_sel;
    wire [19:0]     boot_base;
    wire            bus_req;
    wire            bus_wr;
    wire            go;
    wire            self_ok;

    // new access only when no ack is pending
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;
    // self-programming never on the subsystem clock
    assign self_ok = self_q && !cpu_on_subclk_i;
    // rewrite request launched by a write with go set
    assign go = bus_wr && (wb_adr_i == `FSPG_REG_REQ) &&
                wb_sel_i[3] && wb_dat_i[`FSPG_REQ_GO];

    // window and protection check on the requested block
    fspg_window_check #(
        .BLK_W     (BLK_W),
        .BLK_BYTES (BLK_BYTES)
    ) u_check (
        .blk_i        (wb_dat_i[BLK_W-1:0]),
        .win_start_i  (win_start_q),
        .win_end_i    (win_end_q),
        .self_prog_i  (!serial_prog_i),
        .code_flash_i (!wb_dat_i[`FSPG_REQ_DATA]),
        .bc0_prot_i   (bc0prot_q),
        .in_window_o  (in_win),
        .in_bc0_o     (in_bc0),
        .allow_o      (allow)
    );

    // boot swap flag and boot cluster choice
    fspg_boot_swap u_swap (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .nv_swap_i    (nv_swap_i),
        .set_i        (swap_set),
        .clr_i        (swap_clr),
        .nv_swap_d_o  (nv_d),
        .boot_sel_q_o (boot_sel),
        .boot_base_o  (boot_base)
    );

    // register writes, request acceptance and bus answer
    always @*
    begin
        self_d      = self_q;
        vmode_d     = vmode_q;
        bc0prot_d   = bc0prot_q;
        win_start_d = win_start_q;
        win_end_d   = win_end_q;
        result_d    = result_q;
        busy_d      = busy_q;
        kind_d      = kind_q;
        data_d      = data_q;
        blk_d       = blk_q;
        swap_set    = 1'b0;
        swap_clr    = 1'b0;
        ack_d       = bus_req;
        rdat_d      = 32'h0000_0000;
        // sequencer finished the running request
        if (busy_q && fl_done_i)
        begin
            busy_d   = 1'b0;
            result_d = `FSPG_RES_OK;
        end
        if (bus_wr)
        begin
            case (wb_adr_i)
            `FSPG_REG_CTRL:
                if (wb_sel_i[0])
                begin
                    self_d  = wb_dat_i[`FSPG_CTRL_SELF];
                    // both voltage modes rewrite alike
                    vmode_d = wb_dat_i[`FSPG_CTRL_VMODE];
                    // protection can be set, released only by reset
                    bc0prot_d = bc0prot_q |
                                wb_dat_i[`FSPG_CTRL_BC0PROT];
                    swap_set = wb_dat_i[`FSPG_CTRL_SWAPSET] &&
                               (self_ok || serial_prog_i);
                    swap_clr = wb_dat_i[`FSPG_CTRL_SWAPCLR] &&
                               serial_prog_i;
                end
            `FSPG_REG_WINDOW:
            begin
                // window writable in either programming mode
                if (wb_sel_i[0])
                    win_start_d = wb_dat_i[BLK_W-1:0];
                if (wb_sel_i[2])
                    win_end_d = wb_dat_i[`FSPG_WIN_END_LSB +: BLK_W];
            end
            default:
                rdat_d = 32'h0000_0000;
            endcase
        end
        // new rewrite request, one at a time
        if (go && !busy_q)
        begin
            kind_d = wb_dat_i[`FSPG_REQ_KIND];
            data_d = wb_dat_i[`FSPG_REQ_DATA];
            blk_d  = wb_dat_i[BLK_W-1:0];
            if (!serial_prog_i && !self_ok)
                result_d = `FSPG_RES_REFUSED;
            // protected cluster 0 is refused even outside the window
            else if (!allow && in_bc0 && bc0prot_q)
                result_d = `FSPG_RES_REFUSED;
            else if (!allow && !in_win)
                result_d = `FSPG_RES_WINDOW;
            else
            begin
                result_d = `FSPG_RES_IDLE;
                busy_d   = 1'b1;
            end
        end
        // read mux
        if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
            `FSPG_REG_CTRL:
                rdat_d = {27'h0, 1'b0, 1'b0, bc0prot_q,
                          vmode_q, self_q};
            `FSPG_REG_WINDOW:
                rdat_d = {{(16-BLK_W){1'b0}}, win_end_q,
                          {(16-BLK_W){1'b0}}, win_start_q};
            `FSPG_REG_STATUS:
                rdat_d = {24'h0, fast_osc_stop_bit_i,
                          flash_op_mode_sel_hi_i,
                          flash_op_mode_sel_lo_i, serial_prog_i,
                          cpu_on_subclk_i, self_ok, busy_q, nv_swap_i};
            `FSPG_REG_REQ:
                rdat_d = {busy_q, 13'h0, data_q, kind_q,
                          {(16-BLK_W){1'b0}}, blk_q};
            `FSPG_REG_RESULT:
                rdat_d = {30'h0, result_q};
            `FSPG_REG_BOOT:
                rdat_d = {11'h0, boot_sel, boot_base};
            default:
                rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // register update
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            self_q      <= 1'b0;
            vmode_q     <= 1'b0;
            bc0prot_q   <= 1'b0;
            win_start_q <= `FSPG_WIN_START_RST;
            win_end_q   <= `FSPG_WIN_END_RST;
            result_q    <= `FSPG_RES_IDLE;
            busy_q      <= 1'b0;
            kind_q      <= `FSPG_KIND_ERASE;
            data_q      <= 1'b0;
            blk_q       <= {BLK_W{1'b0}};
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
        end
        else
        begin
            self_q      <= self_d;
            vmode_q     <= vmode_d;
            bc0prot_q   <= bc0prot_d;
            win_start_q <= win_start_d;
            win_end_q   <= win_end_d;
            result_q    <= result_d;
            busy_q      <= busy_d;
            kind_q      <= kind_d;
            data_q      <= data_d;
            blk_q       <= blk_d;
            wb_ack_o    <= ack_d;
            wb_dat_o    <= rdat_d;
        end
    end

    // registered outputs to sequencer, swap store and boot logic
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fl_req_o        <= 1'b0;
            fl_kind_o       <= 1'b0;
            fl_data_o       <= 1'b0;
            fl_blk_o        <= {BLK_W{1'b0}};
            fl_full_speed_o <= 1'b1;
            nv_swap_we_o    <= 1'b0;
            nv_swap_o       <= 1'b0;
            boot_base_o     <= `FSPG_BC0_BASE;
            self_active_o   <= 1'b0;
        end
        else
        begin
            fl_req_o        <= busy_d;
            fl_kind_o       <= kind_d;
            fl_data_o       <= data_d;
            fl_blk_o        <= blk_d;
            // argument zero selects full speed
            fl_full_speed_o <= !vmode_q;
            nv_swap_we_o    <= swap_set || swap_clr;
            nv_swap_o       <= nv_d;
            boot_base_o     <= boot_base;
            self_active_o   <= self_ok && !serial_prog_i;
        end
    end
endmodule

/* File: design/fspg_map.vh */
// constants and register map of the flash self-program guard
// How it works
// - no self-programming on subsystem clock
// - both voltage modes allow write and erase
// - boot clusters span 4 KB, swap exchanges them
// - swap request makes cluster 1 boot area
// - swap persists, every reset boots swapped cluster
// - window set by start and end blocks
// - window settable in self and serial programming
// - self-programming of code flash outside window is blocked
// - serial programming ignores the window
// - cluster 0 protection beats the window
// - window checks code flash only
// - cluster 0 spans 00000H to 00FFFH
`ifndef FSPG_MAP_VH
`define FSPG_MAP_VH

// wishbone word offsets (byte addresses)
`define FSPG_REG_CTRL      8'h00
`define FSPG_REG_WINDOW    8'h04
`define FSPG_REG_STATUS    8'h08
`define FSPG_REG_REQ       8'h0C
`define FSPG_REG_RESULT    8'h10
`define FSPG_REG_BOOT      8'h14

// ctrl register fields
`define FSPG_CTRL_SELF     0
`define FSPG_CTRL_VMODE    1
`define FSPG_CTRL_BC0PROT  2
`define FSPG_CTRL_SWAPSET  3
`define FSPG_CTRL_SWAPCLR  4

// request register fields
`define FSPG_REQ_BLK_LO    0
`define FSPG_REQ_KIND      16
`define FSPG_REQ_DATA      17
`define FSPG_REQ_GO        31

// kinds of rewrite request
`define FSPG_KIND_ERASE    1'b0
`define FSPG_KIND_WRITE    1'b1

// result codes
`define FSPG_RES_IDLE      2'h0
`define FSPG_RES_OK        2'h1
`define FSPG_RES_WINDOW    2'h2
`define FSPG_RES_REFUSED   2'h3

// cluster geometry: cluster 0 at 00000H, cluster 1 at 01000H
`define FSPG_CLUSTER_BYTES 32'h0000_1000
`define FSPG_BC0_BASE      20'h00000
`define FSPG_BC0_LAST      20'h00FFF
`define FSPG_BC1_BASE      20'h01000

// reset value of the window: everything open
`define FSPG_WIN_START_RST 8'h00
`define FSPG_WIN_END_RST   8'hFF

// lowest bit of the window end field in the window register
`define FSPG_WIN_END_LSB   16

`endif

/* File: design/fspg_window_check.v */
// block range check for the shield window and cluster 0 protection
`timescale 1ns/10ps
`include "fspg_map.vh"
module fspg_window_check #(
    parameter BLK_W      = 8,
    parameter BLK_BYTES  = 1024
) (
    input  wire [BLK_W-1:0] blk_i,
    input  wire [BLK_W-1:0] win_start_i,
    input  wire [BLK_W-1:0] win_end_i,
    input  wire             self_prog_i,
    input  wire             code_flash_i,
    input  wire             bc0_prot_i,
    output wire             in_window_o,
    output wire             in_bc0_o,
    output wire             allow_o
);
    // blocks covered by one boot cluster
    localparam [31:0] BC0_BLKS = `FSPG_CLUSTER_BYTES / BLK_BYTES;

    // inclusive window compare
    assign in_window_o = (blk_i >= win_start_i) &&
                         (blk_i <= win_end_i);
    // cluster 0 from block 0 up to 00FFFH
    assign in_bc0_o    = ({{(32-BLK_W){1'b0}}, blk_i} <
                          BC0_BLKS);

    // protection first, then window only for self code rewrites
    assign allow_o = (code_flash_i && bc0_prot_i && in_bc0_o) ? 1'b0 :
                     (!code_flash_i) ? 1'b1 :
                     (!self_prog_i)  ? 1'b1 :
                     in_window_o;
endmodule

/* File: design/fspg_boot_swap.v */
// boot swap flag with nonvolatile copy and cluster selection that follows it every cycle
`timescale 1ns/10ps
`include "fspg_map.vh"
module fspg_boot_swap (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        nv_swap_i,
    input  wire        set_i,
    input  wire        clr_i,
    output reg         nv_swap_d_o,
    output reg         boot_sel_q_o,
    output reg  [19:0] boot_base_o
);
    // the nonvolatile copy is written here, survives reset outside
    always @*
    begin
        nv_swap_d_o = nv_swap_i;
        if (clr_i)
            nv_swap_d_o = 1'b0;
        if (set_i)
            nv_swap_d_o = 1'b1;
    end

    // cluster used for boot, follows nonvolatile copy every cycle, cleared in reset
    always @(posedge clk_i)
    begin
        if (rst_i)
            boot_sel_q_o <= 1'b0;
        else
            boot_sel_q_o <= nv_swap_i;
    end

    // start address of the active boot cluster
    always @*
    begin
        if (boot_sel_q_o)
            boot_base_o = `FSPG_BC1_BASE;
        else
            boot_base_o = `FSPG_BC0_BASE;
    end
endmodule

/* File: dv/fspg_guard_checker.sv */
// port assertions for the flash self-program guard
`timescale 1ns/10ps
module fspg_guard_checker #(
    parameter BLK_W = 8
) (
    input wire             clk_i,
    input wire             rst_i,
    input wire             wb_cyc_i,
    input wire             wb_stb_i,
    input wire             wb_ack_o,
    input wire             cpu_on_subclk_i,
    input wire             serial_prog_i,
    input wire             nv_swap_i,
    input wire             nv_swap_we_o,
    input wire             nv_swap_o,
    input wire             fl_req_o,
    input wire             fl_done_i,
    input wire [BLK_W-1:0] fl_blk_o,
    input wire [19:0]      boot_base_o,
    input wire             self_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus request taken, stored swap flag settled out of reset
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_nv_hi;
        (!rst_i && nv_swap_i)[*3];
    endsequence
    sequence s_nv_lo;
        (!rst_i && !nv_swap_i)[*3];
    endsequence
    property p_ack_next; s_take |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_subclk_off;
        cpu_on_subclk_i && $past(cpu_on_subclk_i) |-> !self_active_o;
    endproperty
    property p_serial_off;
        serial_prog_i && $past(serial_prog_i) |-> !self_active_o;
    endproperty
    property p_req_cause;
        $rose(fl_req_o) |-> $past(serial_prog_i) || $past(self_active_o);
    endproperty
    property p_req_hold;
        fl_req_o && !fl_done_i |=> fl_req_o && $stable(fl_blk_o);
    endproperty
    property p_req_end; fl_req_o && fl_done_i |=> !fl_req_o; endproperty
    property p_base_legal;
        boot_base_o == 20'h00000 || boot_base_o == 20'h01000;
    endproperty
    property p_boot_swapped; s_nv_hi |-> boot_base_o == 20'h01000; endproperty
    property p_boot_plain; s_nv_lo |-> boot_base_o == 20'h00000; endproperty
    property p_nv_set; nv_swap_we_o && !serial_prog_i |-> nv_swap_o; endproperty
    // bus answer, request gating, boot cluster selection
    a_ack_next: assert property (p_ack_next)
        else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_subclk_off: assert property (p_subclk_off)
        else $error("self active on slow clock");
    a_serial_off: assert property (p_serial_off)
        else $error("self active in serial mode");
    a_req_cause: assert property (p_req_cause)
        else $error("request started without permission");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped or block changed");
    a_req_end: assert property (p_req_end)
        else $error("request kept after done");
    a_base_legal: assert property (p_base_legal)
        else $error("boot base not a cluster start");
    a_boot_swapped: assert property (p_boot_swapped)
        else $error("swapped flag not booting cluster 1");
    a_boot_plain: assert property (p_boot_plain)
        else $error("plain flag not booting cluster 0");
    a_nv_set: assert property (p_nv_set)
        else $error("swap stored as clear outside serial");
endmodule

bind fspg_guard fspg_guard_checker #(.BLK_W(BLK_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .cpu_on_subclk_i(cpu_on_subclk_i),
    .serial_prog_i(serial_prog_i), .nv_swap_i(nv_swap_i),
    .nv_swap_we_o(nv_swap_we_o), .nv_swap_o(nv_swap_o), .fl_req_o(fl_req_o),
    .fl_done_i(fl_done_i), .fl_blk_o(fl_blk_o), .boot_base_o(boot_base_o),
    .self_active_o(self_active_o));

/* File: dv/fspg_guard_tb.sv */
// self-checking bench for the flash self-program guard
`timescale 1ns/10ps
`include "fspg_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module fspg_guard_tb;
    reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wdat = 32'h0, q;
    reg         subclk = 0, serial = 0, nv = 0, done = 0, osc_stop = 1;
    reg  [2:0]  cnt = 3'h0;
    integer     failures = 0, samples_checked = 0, cycles = 0, i;
    wire [31:0] rdat;
    wire        ack, nv_we, nv_val, req, kind, dfl, full, act;
    wire [7:0]  blk;
    wire [19:0] base;
    always #5 clk_i = ~clk_i;
    fspg_guard u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_on_subclk_i(subclk),
        .serial_prog_i(serial), .flash_op_mode_sel_hi_i(1'b1),
        .flash_op_mode_sel_lo_i(1'b0), .fast_osc_stop_bit_i(osc_stop),
        .nv_swap_i(nv), .nv_swap_we_o(nv_we), .nv_swap_o(nv_val),
        .fl_req_o(req), .fl_kind_o(kind), .fl_data_o(dfl), .fl_blk_o(blk),
        .fl_full_speed_o(full), .fl_done_i(done), .boot_base_o(base),
        .self_active_o(act));
    // sequencer, nonvolatile cell and hang guard
    always @(posedge clk_i)
    begin
        cnt <= req ? cnt + 3'h1 : 3'h0;
        done <= (cnt == 3'h2);
        if (nv_we) nv <= nv_val;
        cycles <= cycles + 1;
        if (cycles == 8000) begin failures++; close_out; end
    end
    // one classic wishbone cycle
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    end
    endtask
    task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
        bus(1'b0, a, 32'h0);
        `CHK("register", e, q & m)
    end
    endtask
    // rewrite request, then poll the result code
    task rewrite(input [7:0] b, input k, input df, input [1:0] e);
    begin
        bus(1'b1, `FSPG_REG_REQ, {1'b1, 13'h0, df, k, 8'h00, b});
        `CHK("request", e == `FSPG_RES_OK, req)
        if (e == `FSPG_RES_OK) `CHK("flash block", {k, df, b}, {kind, dfl, blk})
        q = 32'h0;
        repeat (8) if (q[1:0] == 2'h0) bus(1'b0, `FSPG_REG_RESULT, 32'h0);
        `CHK("result", {30'h0, e}, q)
    end
    endtask
    task close_out;
    begin
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("full speed", 1'b1, full)
        rd_chk(`FSPG_REG_WINDOW, 32'hFFFF_FFFF, 32'h00FF_0000);
        rd_chk(`FSPG_REG_BOOT, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0);
        rd_chk(`FSPG_REG_STATUS, 32'hE0, 32'hC0);
        // oscillator restarted, 30 us settle before any rewrite
        osc_stop <= 1'b0;
        repeat (3000) @(posedge clk_i);
        rd_chk(`FSPG_REG_STATUS, 32'h80, 32'h0);
        subclk <= 1'b1;
        bus(1'b1, `FSPG_REG_CTRL, 32'h1);
        rewrite(8'h08, 1'b1, 1'b0, `FSPG_RES_REFUSED);
        subclk <= 1'b0;
        repeat (2) @(posedge clk_i);
        rewrite(8'h08, 1'b1, 1'b0, `FSPG_RES_OK);
        bus(1'b1, `FSPG_REG_CTRL, 32'h3);
        `CHK("full speed", 1'b0, full)
        rewrite(8'h08, 1'b0, 1'b0, `FSPG_RES_OK);
        bus(1'b1, `FSPG_REG_WINDOW, 32'h0006_0004);
        rd_chk(`FSPG_REG_WINDOW, 32'hFFFF_FFFF, 32'h0006_0004);
        // blocks 3, 4, 6, 7 against window 4..6
        for (i = 0; i < 4; i++)
            rewrite(8'(i < 2 ? 3 + i : 4 + i), i[0], 1'b0, (i == 1 || i == 2)
                ? `FSPG_RES_OK : `FSPG_RES_WINDOW);
        rewrite(8'h07, 1'b1, 1'b1, `FSPG_RES_OK);
        serial <= 1'b1;
        repeat (2) @(posedge clk_i);
        rewrite(8'h07, 1'b0, 1'b0, `FSPG_RES_OK);
        bus(1'b1, `FSPG_REG_WINDOW, 32'h00FF_0000);
        rd_chk(`FSPG_REG_WINDOW, 32'hFFFF_FFFF, 32'h00FF_0000);
        serial <= 1'b0;
        repeat (2) @(posedge clk_i);
        bus(1'b1, `FSPG_REG_CTRL, 32'h5);
        rewrite(8'h02, 1'b0, 1'b0, `FSPG_RES_REFUSED);
        rewrite(8'h04, 1'b1, 1'b0, `FSPG_RES_OK);
        rd_chk(`FSPG_REG_REQ, 32'hFFFF_FFFF, 32'h0001_0004);
        bus(1'b1, `FSPG_REG_CTRL, 32'hD);
        repeat (4) @(posedge clk_i);
        `CHK("boot base", 20'h01000, base)
        rd_chk(`FSPG_REG_BOOT, 32'hFFFF_FFFF, 32'h0010_1000);
        rd_chk(`FSPG_REG_STATUS, 32'h1, 32'h1);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("boot base", 20'h01000, base)
        close_out;
    end
endmodule
